// ==== rtl/pltc_map.svh ====
/*
  Register map, field positions and reset values of the panel line timing block.
  Assumes inclusion by bare name from the top module and the checker.
*/
`ifndef PLTC_MAP_SVH
`define PLTC_MAP_SVH

// ==========================================================
// Register byte offsets
`define PLTC_OFF_CTRL 8'h00
`define PLTC_OFF_TIM0 8'h04
`define PLTC_OFF_TIM2 8'h08
`define PLTC_OFF_STAT 8'h0c
`define PLTC_OFF_ICLR 8'h10
`define PLTC_OFF_IEN 8'h14

// ==========================================================
// Control word fields
`define PLTC_CTRL_ON_BIT 0
`define PLTC_CTRL_MONO_BIT 1
`define PLTC_CTRL_ACT_BIT 7
`define PLTC_CTRL_MASK 32'h00000083
`define PLTC_CTRL_RST 32'h00000000

// ==========================================================
// Timing word two fields
`define PLTC_TIM2_INV_BIT 0
`define PLTC_TIM2_MASK 32'h00000001

// ==========================================================
// Line timing fields
`define PLTC_LEAD_HI 31
`define PLTC_LEAD_LO 24
`define PLTC_TAIL_HI 23
`define PLTC_TAIL_LO 16
`define PLTC_PW_HI 15
`define PLTC_PW_LO 10
`define PLTC_PPL_HI 9
`define PLTC_PPL_LO 0

// ==========================================================
// Status and interrupt layout
`define PLTC_EV_W 2
`define PLTC_EV_FRAME 0
`define PLTC_EV_LINE 1

// ==========================================================
// Panel data lanes
`define PLTC_MONO_MASK 16'h000f
`define PLTC_COLOR_MASK 16'h00ff
`define PLTC_ACT_MASK 16'hffff

`endif

// ==== rtl/pltc_pkg.sv ====
/*
  Types shared by the panel line timing block.
  Assumes nothing of its surroundings.
*/
package pltc_pkg;
  typedef logic [31:0] pltc_word_t;
  typedef logic [15:0] pltc_pix_t;
  typedef logic [9:0] pltc_cnt_t;
  typedef enum logic [2:0] {
    PLTC_IDLE,
    PLTC_LEAD,
    PLTC_PIXELS,
    PLTC_TAIL,
    PLTC_PULSE
  } pltc_state_t;
endpackage : pltc_pkg

// ==== rtl/pltc_top.sv ====
/*
  Horizontal line timing generator of a flat panel controller with its
  AHB-Lite register slave and interrupt logic.
  Assumes a single AHB-Lite master doing whole-word single transfers, a
  free-running pixel reference clock from outside the hclk domain, and
  pixel data presented by same-clock upstream logic on request.
*/
`timescale 1ns/10ps
`default_nettype none
`include "pltc_map.svh"

module pltc_top
  import pltc_pkg::*;
#(
  parameter int FRAME_LINES = 240
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire pltc_pkg::pltc_word_t hwdata,
  output pltc_pkg::pltc_word_t hrdata,
  output logic hreadyout,
  output logic hresp,
  // Pixel source
  input wire pltc_pkg::pltc_pix_t pixel_data,
  output logic pixel_req,
  // Panel link
  input wire logic pix_ref_clk,
  output logic pixel_clock_pin,
  output logic line_clock_pin,
  output pltc_pkg::pltc_pix_t panel_data_pins,
  // Interrupt
  output logic irq
);
  import pltc_pkg::*;

  localparam int LW = $clog2(FRAME_LINES);

  // ==========================================================
  // Helpers
  function automatic pltc_pix_t lane_mask(input pltc_pix_t d, input logic act,
                                          input logic mono);
    if (act)
      lane_mask = d & `PLTC_ACT_MASK;
    else if (mono)
      lane_mask = d & `PLTC_MONO_MASK;
    else
      lane_mask = d & `PLTC_COLOR_MASK;
  endfunction : lane_mask

  // ==========================================================
  // Register state
  pltc_word_t ctrl_r, ctrl_nxt;
  pltc_word_t tim0_r, tim0_nxt;
  pltc_word_t tim2_r, tim2_nxt;
  logic [`PLTC_EV_W-1:0] stat_r, stat_nxt;
  logic [`PLTC_EV_W-1:0] ien_r, ien_nxt;
  logic wr_pend_r, wr_pend_nxt;
  logic [7:0] addr_r, addr_nxt;
  pltc_word_t hrdata_r, hrdata_nxt;
  logic [`PLTC_EV_W-1:0] ev;
  logic sel_ok;

  // ==========================================================
  // Timing state
  pltc_state_t state_r, state_nxt;
  pltc_cnt_t cnt_r, cnt_nxt;
  logic [LW-1:0] line_r, line_nxt;
  pltc_pix_t data_r, data_nxt;
  logic pclk_r, pclk_nxt;
  logic lclk_r, lclk_nxt;
  logic ref_s1_r, ref_s2_r, ref_s3_r;
  logic tick;

  logic ctrl_on, mono, act, inv;
  assign ctrl_on = ctrl_r[`PLTC_CTRL_ON_BIT];
  assign mono = ctrl_r[`PLTC_CTRL_MONO_BIT];
  assign act = ctrl_r[`PLTC_CTRL_ACT_BIT];
  assign inv = tim2_r[`PLTC_TIM2_INV_BIT];

  // ==========================================================
  // Bus slave: zero wait states, always OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_r;
  assign sel_ok = hsel & hready & htrans[1];

  always_comb begin
    ctrl_nxt = ctrl_r;
    tim0_nxt = tim0_r;
    tim2_nxt = tim2_r;
    stat_nxt = stat_r;
    ien_nxt = ien_r;
    hrdata_nxt = hrdata_r;
    wr_pend_nxt = sel_ok & hwrite;
    // Address phase is held so the write lands at the end of its data phase
    addr_nxt = sel_ok ? haddr : addr_r;
    if (wr_pend_r) begin
      case (addr_r)
        `PLTC_OFF_CTRL: ctrl_nxt = hwdata & `PLTC_CTRL_MASK;
        `PLTC_OFF_TIM0: tim0_nxt = hwdata;
        `PLTC_OFF_TIM2: tim2_nxt = hwdata & `PLTC_TIM2_MASK;
        `PLTC_OFF_ICLR: stat_nxt = stat_r & ~hwdata[`PLTC_EV_W-1:0];
        `PLTC_OFF_IEN: ien_nxt = hwdata[`PLTC_EV_W-1:0];
        default: ;
      endcase
    end
    // Set wins over a clear in the same cycle
    stat_nxt = stat_nxt | ev;
    // Read data loads at the address edge and stands through the data phase
    if (sel_ok && !hwrite) begin
      case (haddr)
        `PLTC_OFF_CTRL: hrdata_nxt = ctrl_r | ~`PLTC_CTRL_MASK;
        `PLTC_OFF_TIM0: hrdata_nxt = tim0_r;
        `PLTC_OFF_TIM2: hrdata_nxt = tim2_r | ~`PLTC_TIM2_MASK;
        `PLTC_OFF_STAT: hrdata_nxt = {{(32-`PLTC_EV_W){1'b0}}, stat_r};
        `PLTC_OFF_IEN: hrdata_nxt = {{(32-`PLTC_EV_W){1'b0}}, ien_r};
        default: hrdata_nxt = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_r <= `PLTC_CTRL_RST;
      tim0_r <= 32'h00000000;
      tim2_r <= 32'h00000000;
      stat_r <= '0;
      ien_r <= '0;
      wr_pend_r <= 1'b0;
      addr_r <= 8'h00;
      hrdata_r <= 32'h00000000;
    end else begin
      ctrl_r <= ctrl_nxt;
      tim0_r <= tim0_nxt;
      tim2_r <= tim2_nxt;
      stat_r <= stat_nxt;
      ien_r <= ien_nxt;
      wr_pend_r <= wr_pend_nxt;
      addr_r <= addr_nxt;
      hrdata_r <= hrdata_nxt;
    end
  end

  // Level output; it drops only when software clears or masks the flag
  // enabled flags raise the request
  assign irq = |(stat_r & ien_r);

  // ==========================================================
  // Pixel reference synchroniser and edge finder
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ref_s1_r <= 1'b0;
      ref_s2_r <= 1'b0;
      ref_s3_r <= 1'b0;
    end else begin
      ref_s1_r <= pix_ref_clk;
      ref_s2_r <= ref_s1_r;
      ref_s3_r <= ref_s2_r;
    end
  end

  assign tick = ref_s2_r & ~ref_s3_r;
  assign pixel_req = tick && (state_r == PLTC_PIXELS);

  // ==========================================================
  // Line sequencer
  // Timing fields are read live; software keeps them still while running.
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    line_nxt = line_r;
    data_nxt = data_r;
    ev = '0;
    case (state_r)
      PLTC_IDLE: begin
        data_nxt = 16'h0000;
        if (ctrl_on) begin
          state_nxt = PLTC_LEAD;
          cnt_nxt = {2'b00, tim0_r[`PLTC_LEAD_HI:`PLTC_LEAD_LO]};
          // An enable from idle starts a fresh frame at line zero
          line_nxt = '0;
        end
      end
      PLTC_LEAD: begin
        if (tick) begin
          if (cnt_r == 10'h000) begin
            state_nxt = PLTC_PIXELS;
            cnt_nxt = tim0_r[`PLTC_PPL_HI:`PLTC_PPL_LO];
          end else
            cnt_nxt = cnt_r - 10'h001;
        end
      end
      PLTC_PIXELS: begin
        if (tick) begin
          data_nxt = lane_mask(pixel_data, act, mono);
          if (cnt_r == 10'h000) begin
            state_nxt = PLTC_TAIL;
            cnt_nxt = {2'b00, tim0_r[`PLTC_TAIL_HI:`PLTC_TAIL_LO]};
          end else
            cnt_nxt = cnt_r - 10'h001;
        end
      end
      PLTC_TAIL: begin
        if (tick) begin
          if (cnt_r == 10'h000) begin
            state_nxt = PLTC_PULSE;
            cnt_nxt = {4'h0, tim0_r[`PLTC_PW_HI:`PLTC_PW_LO]};
          end else
            cnt_nxt = cnt_r - 10'h001;
        end
      end
      PLTC_PULSE: begin
        if (tick) begin
          if (cnt_r == 10'h000) begin
            ev[`PLTC_EV_LINE] = 1'b1;
            state_nxt = PLTC_LEAD;
            cnt_nxt = {2'b00, tim0_r[`PLTC_LEAD_HI:`PLTC_LEAD_LO]};
            line_nxt = line_r + 1'b1;
            if (line_r == LW'(FRAME_LINES - 1)) begin
              line_nxt = '0;
              if (!ctrl_on) begin
                state_nxt = PLTC_IDLE;
                ev[`PLTC_EV_FRAME] = 1'b1;
              end
            end
          end else
            cnt_nxt = cnt_r - 10'h001;
        end
      end
      default: state_nxt = PLTC_IDLE;
    endcase
    // Pin follows the synchronised reference, so it lags the link clock by three cycles
    // passive gates pixel clock outside pixels
    pclk_nxt = (state_r != PLTC_IDLE) && ref_s2_r && (act || (state_r == PLTC_PIXELS));
    lclk_nxt = (state_nxt == PLTC_PULSE) ^ inv;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r <= PLTC_IDLE;
      cnt_r <= 10'h000;
      line_r <= '0;
      data_r <= 16'h0000;
      pclk_r <= 1'b0;
      lclk_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      line_r <= line_nxt;
      data_r <= data_nxt;
      pclk_r <= pclk_nxt;
      lclk_r <= lclk_nxt;
    end
  end

  assign pixel_clock_pin = pclk_r;
  assign line_clock_pin = lclk_r;
  assign panel_data_pins = data_r;

endmodule : pltc_top
`default_nettype wire

// ==== testbench/pltc_chk.sv ====
/* Port checker for pltc_top.
   Assumes single-word bus writes; bound at the foot of this file. */
`timescale 1ns/10ps
`default_nettype none
`include "pltc_map.svh"
module pltc_chk
  import pltc_pkg::*;
(
  // Bus
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire pltc_pkg::pltc_word_t hwdata,
  // Panel
  input wire pltc_pkg::pltc_pix_t pixel_data,
  input wire logic pixel_req,
  input wire logic pixel_clock_pin,
  input wire logic line_clock_pin,
  input wire pltc_pkg::pltc_pix_t panel_data_pins
);
  // ======
  // Mode shadow, decoded from bus writes
  logic wp_r, wp_nxt, inv_r, inv_nxt, on_r, on_nxt, la;
  logic [7:0] wa_r, wa_nxt, ctl_r, ctl_nxt;
  pltc_pix_t msk;
  always_comb begin
    wp_nxt = hsel && hready && htrans[1] && hwrite;
    wa_nxt = haddr;
    ctl_nxt = (wp_r && wa_r == `PLTC_OFF_CTRL) ? hwdata[7:0] : ctl_r;
    on_nxt = on_r || ctl_nxt[0];
    inv_nxt = (wp_r && wa_r == `PLTC_OFF_TIM2) ? hwdata[0] : inv_r;
    la = line_clock_pin ^ inv_r;
    msk = ctl_r[7] ? `PLTC_ACT_MASK : (ctl_r[1] ? `PLTC_MONO_MASK : `PLTC_COLOR_MASK);
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {wp_r, wa_r, ctl_r, inv_r, on_r} <= '0;
    end else begin
      {wp_r, wa_r, ctl_r, inv_r, on_r} <= {wp_nxt, wa_nxt, ctl_nxt, inv_nxt, on_nxt};
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ======
  // Properties; a one-cycle polarity glitch while idle is why two-cycle antecedents
  property p_lanes; pixel_req |=> panel_data_pins == ($past(pixel_data) & msk); endproperty
  a_lanes: assert property (p_lanes) else $error("lane data wrong");
  property p_off; !on_r |-> !pixel_req && panel_data_pins == 16'h0000; endproperty
  a_off: assert property (p_off) else $error("active before enable");
  property p_one; pixel_req |=> !pixel_req [*6]; endproperty
  a_one: assert property (p_one) else $error("pixel ticks too close");
  property p_tail; pixel_req |-> !la [*7]; endproperty
  a_tail: assert property (p_tail) else $error("line clock near pixels");
  property p_lead; $fell(la) |-> !pixel_req [*5]; endproperty
  a_lead: assert property (p_lead) else $error("no lead wait");
  property p_pulse; $rose(la) |-> !pixel_req [*8]; endproperty
  a_pulse: assert property (p_pulse) else $error("pixels in line pulse");
  property p_quiet; !ctl_r[7] && la && $past(la) |-> $stable(pixel_clock_pin); endproperty
  a_quiet: assert property (p_quiet) else $error("passive clock moved");
  property p_tog; ctl_r[7] && la && $past(la) |-> ##[0:8] $changed(pixel_clock_pin); endproperty
  a_tog: assert property (p_tog) else $error("active clock stuck");
endmodule : pltc_chk
bind pltc_top pltc_chk u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hwdata(hwdata),
  .pixel_data(pixel_data), .pixel_req(pixel_req), .pixel_clock_pin(pixel_clock_pin),
  .line_clock_pin(line_clock_pin), .panel_data_pins(panel_data_pins));
`default_nettype wire

// ==== testbench/pltc_panel.sv ====
/* Panel and pixel source model; measures each line.
   Assumes the bench passes its copy of the line clock polarity. */
`timescale 1ns/10ps
`default_nettype none
module pltc_panel
  import pltc_pkg::*;
(
  // Inputs
  input wire logic hclk,
  input wire logic inv,
  input wire logic pixel_req,
  input wire logic line_clock_pin,
  // Drives and measures
  output logic pix_ref_clk,
  output pltc_pkg::pltc_pix_t pixel_data,
  output int npix,
  output int wid,
  output int per,
  output int nl
);
  logic la, la_r;
  int pc, wc, cc;
  assign la = line_clock_pin ^ inv;
  // ======
  // Free reference, phase unrelated to hclk
  initial begin
    {pix_ref_clk, la_r, pixel_data, pc, wc, cc, npix, wid, per, nl} = '0;
    #5;
    forever #32 pix_ref_clk = ~pix_ref_clk;
  end
  // Source never holds its word, so a late sample shows
  always @(posedge hclk) begin
    pixel_data <= pixel_data + 16'h3a5b;
    la_r <= la;
    cc <= cc + 1;
    if (pixel_req) pc <= pc + 1;
    if (la) wc <= wc + 1;
    if (!la && la_r) wid <= wc;
    if (la && !la_r) begin
      npix <= pc;
      pc <= 0;
      per <= cc;
      cc <= 1;
      wc <= 1;
      nl <= nl + 1;
    end
  end
endmodule : pltc_panel
`default_nettype wire

// ==== testbench/tb_panel_line_timing_control.sv ====
/* Bench for pltc_top: registers, three panel modes, interrupt.
   Assumes the checker binds itself and the panel model drives the link. */
`timescale 1ns/10ps
`default_nettype none
module tb_panel_line_timing_control;
  import pltc_pkg::*;
  logic hclk, hresetn, hsel, hwrite, inv, hreadyout, pixel_req, pix_ref_clk;
  logic pixel_clock_pin, line_clock_pin, irq, hresp;
  logic [7:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize;
  pltc_word_t hwdata, hrdata, q;
  pltc_pix_t pixel_data, panel_data_pins;
  int npix, wid, per, nl, n_fail, checks_done;
  always #4 hclk = ~hclk;
  pltc_top #(.FRAME_LINES(3)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
    .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .pixel_data(pixel_data), .pixel_req(pixel_req), .pix_ref_clk(pix_ref_clk),
    .pixel_clock_pin(pixel_clock_pin), .line_clock_pin(line_clock_pin),
    .panel_data_pins(panel_data_pins), .irq(irq));
  pltc_panel u_panel (.hclk(hclk), .inv(inv), .pixel_req(pixel_req),
    .line_clock_pin(line_clock_pin), .pix_ref_clk(pix_ref_clk), .pixel_data(pixel_data),
    .npix(npix), .wid(wid), .per(per), .nl(nl));
  // ======
  // Tasks
  task automatic chk(input pltc_word_t got, input pltc_word_t exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [7:0] a, input pltc_word_t d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
    #1;
  endtask : bus
  task automatic rd(input logic [7:0] a, input pltc_word_t exp);
    bus(1'b0, a, 32'h0);
    chk(q, exp);
  endtask : rd
  task automatic run(input pltc_word_t tim, input logic [7:0] ctl);
    int n0;
    bus(1'b1, 8'h04, tim);
    rd(8'h04, tim);
    n0 = nl;
    bus(1'b1, 8'h00, {24'h0, ctl} | 32'h1);
    for (int i = 0; i < 20000 && nl < n0 + 3; i++) @(posedge hclk);
    chk(npix, tim[9:0] + 32'd1);
    chk(wid, 32'd8 * (tim[15:10] + 32'd1));
    chk(per, 32'd8 * (tim[31:24] + tim[23:16] + tim[15:10] + tim[9:0] + 32'd4));
    bus(1'b1, 8'h00, {24'h0, ctl});
    for (int i = 0; i < 20000 && irq !== 1'b1; i++) @(posedge hclk);
    chk(irq, 1'b1);
    chk((nl - n0) % 3, 0);
    n0 = nl;
    repeat (300) @(posedge hclk);
    chk(nl, n0);
    rd(8'h0c, 32'h3);
    bus(1'b1, 8'h14, 32'h0);
    chk(irq, 1'b0);
    bus(1'b1, 8'h14, 32'h1);
    chk(irq, 1'b1);
    bus(1'b1, 8'h10, 32'h1);
    chk(irq, 1'b0);
    rd(8'h0c, 32'h2);
    bus(1'b1, 8'h10, 32'h2);
    rd(8'h0c, 32'h0);
  endtask : run
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : wrap_up
  // ======
  // Sequence
  initial begin
    {hclk, hresetn, hsel, hwrite, inv, haddr, htrans, hwdata, n_fail, checks_done} = '0;
    hsize = 3'b010;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(8'h00, 32'hffffff7c);
    rd(8'h08, 32'hfffffffe);
    rd(8'h0c, 32'h0);
    bus(1'b1, 8'h40, 32'hffffffff);
    chk(hresp, 1'b0);
    rd(8'h40, 32'h0);
    bus(1'b1, 8'h00, 32'hffffff00);
    rd(8'h00, 32'hffffff7c);
    bus(1'b1, 8'h08, 32'h1);
    inv = 1'b1;
    rd(8'h08, 32'hffffffff);
    bus(1'b1, 8'h14, 32'h1);
    run(32'h02010c04, 8'h80);
    bus(1'b1, 8'h08, 32'h0);
    inv = 1'b0;
    run(32'h00040001, 8'h02);
    run(32'h05000407, 8'h00);
    wrap_up();
  end
  // Watchdog well past the expected few tens of microseconds
  initial begin
    #200000;
    n_fail++;
    wrap_up();
  end
endmodule : tb_panel_line_timing_control
`default_nettype wire
